/* File: rtl/parallel_nvm_programming_port.sv */
// device side of the high-voltage parallel programming port
`timescale 1ns/10ps
`include "nvm_prog_map.svh"
module parallel_nvm_programming_port
   import nvm_prog_pkg::*;
#(
   parameter int         FLASH_AW    = 15,
   parameter int         PAGE_BITS   = 7,
   parameter int         EE_AW       = 11,
   parameter int         EE_PG_BITS  = 3,
   parameter int         PROG_CYCLES =
      int'($ceil(`T_WLRH_MIN_MS * `NS_PER_MS / `CLK_PERIOD_NS)),
   parameter int         ERASE_CYCLES =
      int'($ceil(`T_WLRH_CE_MIN_MS * `NS_PER_MS / `CLK_PERIOD_NS)),
   parameter logic [7:0] SIGNATURE_0 = 8'h5A, // arbitrary value
   parameter logic [7:0] SIGNATURE_1 = 8'h3C, // arbitrary value
   parameter logic [7:0] SIGNATURE_2 = 8'h01, // arbitrary value
   parameter logic [7:0] CALIBRATION = 8'h80,
   parameter logic [7:0] FUSE_LOW_INIT  = 8'hFF,
   parameter logic [7:0] FUSE_HIGH_INIT = 8'hFF,
   parameter logic [7:0] FUSE_EXT_INIT  = 8'hFF
) (
   input  wire logic       clk_sys,
   input  wire logic       sys_rst,
   input  wire logic       loadStrobe,
   input  wire logic       loadActionSelectHi,
   input  wire logic       loadActionSelectLo,
   input  wire logic       byteSelect1,
   input  wire logic       byteSelect2,
   input  wire logic       wordLatchStrobe,
   input  wire logic       programStartStrobeN,
   input  wire logic       outputEnableN,
   input  wire logic [7:0] dataIn,
   output logic [7:0]      dataOut,
   output logic            dataOe,
   output logic            readyFlag
);
   localparam int BUSY_W = $clog2(ERASE_CYCLES + 1);
   localparam logic [BUSY_W-1:0] PROG_LOAD  = BUSY_W'(PROG_CYCLES);
   localparam logic [BUSY_W-1:0] ERASE_LOAD = BUSY_W'(ERASE_CYCLES);

   // storage walks one word per clock, so busy must outlast the walk
   initial begin
      if (PROG_CYCLES <= 2**PAGE_BITS || ERASE_CYCLES <= 2**FLASH_AW ||
          PROG_CYCLES <= 2**EE_PG_BITS || PROG_CYCLES > ERASE_CYCLES)
         $error("parallel_nvm_programming_port: busy time too short");
   end

   typedef struct packed {
      logic              prevLoad;
      logic              prevLatch;
      logic              prevWrite;
      logic [7:0]        command;
      logic [23:0]       address;
      logic [7:0]        dataLo;
      logic [7:0]        dataHi;
      logic [7:0]        fuseLow;
      logic [7:0]        fuseHigh;
      logic [7:0]        fuseExt;
      logic [7:0]        lockBits;
      logic [BUSY_W-1:0] busyCount;
      logic              ready;
      logic [7:0]        dataOut;
      logic              dataOe;
   } state_type;

   state_type st;
   state_type next_st;

   nvm_array_if mem ();

   nvm_array #(
      .FLASH_AW   (FLASH_AW),
      .PAGE_BITS  (PAGE_BITS),
      .EE_AW      (EE_AW),
      .EE_PG_BITS (EE_PG_BITS)
   ) u_array (
      .clk_sys (clk_sys),
      .sys_rst (sys_rst),
      .mem     (mem)
   );

   function automatic logic [1:0] selCode(input logic b2, input logic b1);
      selCode = {b2, b1};
   endfunction

   logic       loadRise;
   logic       latchRise;
   logic       writeFall;
   logic       writeAccept;
   logic       eraseStart;
   logic       progStart;
   logic [1:0] action;
   logic [1:0] sel;
   logic [7:0] readByte;
   logic       lockModeThree;

   assign loadRise  = loadStrobe && !st.prevLoad;
   assign latchRise = wordLatchStrobe && !st.prevLatch;
   assign writeFall = !programStartStrobeN && st.prevWrite;
   // a write edge that lands while busy is dropped, not queued
   assign writeAccept = writeFall && st.ready;
   assign action = {loadActionSelectHi, loadActionSelectLo};
   assign sel    = selCode(byteSelect2, byteSelect1);
   assign lockModeThree = st.lockBits[`LOCK_MODE_RANGE] == `LOCK_MODE_THREE;
   assign eraseStart = writeAccept && st.command == `CMD_CHIP_ERASE;

   always_comb begin
      progStart = 1'b0;
      if (writeAccept) begin
         case (st.command)
            `CMD_WRITE_FLASH:  progStart = sel == `SEL_LOW;
            `CMD_WRITE_EEPROM: progStart = sel == `SEL_LOW;
            `CMD_WRITE_FUSE:   progStart = sel != `SEL_BOTH;
            `CMD_WRITE_LOCK:   progStart = 1'b1;
            default:           progStart = 1'b0;
         endcase
      end
   end

   assign mem.address = st.address;
   assign mem.dataLo  = st.dataLo;
   assign mem.dataHi  = st.dataHi;
   assign mem.flashLatch =
      latchRise && byteSelect1 && st.command == `CMD_WRITE_FLASH;
   assign mem.eepromLatch =
      latchRise && st.command == `CMD_WRITE_EEPROM;
   assign mem.flashCommit =
      progStart && st.command == `CMD_WRITE_FLASH;
   assign mem.eepromCommit =
      progStart && st.command == `CMD_WRITE_EEPROM;
   assign mem.eraseAll = eraseStart;

   // read data follows command, selects and address
   always_comb begin
      readByte = `ERASED_BYTE;
      case (st.command)
         `CMD_READ_FLASH:
            readByte = byteSelect1 ? mem.flashWord[15:8]
                                   : mem.flashWord[7:0];
         `CMD_READ_EEPROM:
            readByte = mem.eepromByte;
         `CMD_READ_FUSE: begin
            case (sel)
               `SEL_LOW:  readByte = st.fuseLow;
               `SEL_HIGH: readByte = st.lockBits;
               `SEL_EXT:  readByte = st.fuseExt;
               default:   readByte = st.fuseHigh;
            endcase
         end
         `CMD_READ_SIG: begin
            if (byteSelect1) begin
               if (st.address[`ADDR_LOW_RANGE] == `CAL_ADDR)
                  readByte = CALIBRATION;
            end else begin
               case (st.address[`ADDR_LOW_RANGE])
                  8'h00:   readByte = SIGNATURE_0;
                  8'h01:   readByte = SIGNATURE_1;
                  `SIG_LAST_ADDR: readByte = SIGNATURE_2;
                  default: readByte = `ERASED_BYTE;
               endcase
            end
         end
         default: readByte = `ERASED_BYTE;
      endcase
   end

   always_comb begin
      next_st = st;
      next_st.prevLoad  = loadStrobe;
      next_st.prevLatch = wordLatchStrobe;
      next_st.prevWrite = programStartStrobeN;
      next_st.dataOe    = !outputEnableN;
      next_st.dataOut   = readByte;
      // command and address are only replaced by a new load
      if (loadRise) begin
         case (action)
            `ACT_ADDR: begin
               case (sel)
                  `SEL_LOW:  next_st.address[`ADDR_LOW_RANGE]  = dataIn;
                  `SEL_HIGH:
                     next_st.address[`ADDR_HIGH_RANGE] = dataIn;
                  `SEL_EXT:  next_st.address[`ADDR_EXT_RANGE]  = dataIn;
                  default:   next_st.address = st.address;
               endcase
            end
            `ACT_DATA: begin
               if (byteSelect1) next_st.dataHi = dataIn;
               else next_st.dataLo = dataIn;
            end
            `ACT_CMD: begin
               next_st.command = dataIn;
               if (dataIn == `CMD_NOP) begin
                  next_st.dataLo = `ERASED_BYTE;
                  next_st.dataHi = `ERASED_BYTE;
               end
            end
            default: next_st.command = st.command;
         endcase
      end
      if (progStart && st.command == `CMD_WRITE_FUSE) begin
         case (sel)
            `SEL_LOW:  next_st.fuseLow  = st.dataLo;
            `SEL_HIGH: next_st.fuseHigh = st.dataLo;
            `SEL_EXT:  next_st.fuseExt  = st.dataLo;
            default:   next_st.fuseLow  = st.fuseLow;
         endcase
      end
      if (progStart && st.command == `CMD_WRITE_LOCK) begin
         // a write can only clear lock bits, never set them
         next_st.lockBits = st.lockBits & st.dataLo;
         if (lockModeThree)
            next_st.lockBits[`BOOT_LOCK_RANGE] =
               st.lockBits[`BOOT_LOCK_RANGE];
      end
      if (eraseStart) next_st.lockBits = `ERASED_BYTE;
      if (!st.ready) begin
         next_st.busyCount = st.busyCount - 1'b1;
         if (st.busyCount == BUSY_W'(1)) next_st.ready = 1'b1;
      end
      if (progStart) begin
         next_st.busyCount = PROG_LOAD;
         next_st.ready     = 1'b0;
      end
      if (eraseStart) begin
         next_st.busyCount = ERASE_LOAD;
         next_st.ready     = 1'b0;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         st <= '{prevLoad: 1'b0, prevLatch: 1'b0, prevWrite: 1'b1,
                 command: `CMD_NOP, address: '0,
                 dataLo: `ERASED_BYTE, dataHi: `ERASED_BYTE,
                 fuseLow: FUSE_LOW_INIT, fuseHigh: FUSE_HIGH_INIT,
                 fuseExt: FUSE_EXT_INIT, lockBits: `ERASED_BYTE,
                 busyCount: '0, ready: 1'b1,
                 dataOut: `ERASED_BYTE, dataOe: 1'b0};
      end else begin
         st <= next_st;
      end
   end

   assign dataOut   = st.dataOut;
   assign dataOe    = st.dataOe;
   assign readyFlag = st.ready;

   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (sys_rst);

   sequence s_flashWriteEdge;
      writeFall && st.ready && st.command == `CMD_WRITE_FLASH &&
         sel == `SEL_LOW;
   endsequence

   property p_flashBusy;
      s_flashWriteEdge |=> !readyFlag ##1 !readyFlag;
   endproperty
   a_flashBusy: assert property (p_flashBusy)
      else $error("flash page write did not drop ready");

   property p_busyHolds;
      $fell(readyFlag) |-> !readyFlag [*8];
   endproperty
   a_busyHolds: assert property (p_busyHolds)
      else $error("ready returned too early");

   property p_busDrive;
      outputEnableN |=> !dataOe;
   endproperty
   a_busDrive: assert property (p_busDrive)
      else $error("data bus driven with output enable high");

   property p_cmdLoad;
      loadRise && action == `ACT_CMD |=> st.command == $past(dataIn);
   endproperty
   a_cmdLoad: assert property (p_cmdLoad)
      else $error("command not captured");

   property p_addrHigh;
      loadRise && action == `ACT_ADDR && sel == `SEL_HIGH
         |=> st.address[`ADDR_HIGH_RANGE] == $past(dataIn);
   endproperty
   a_addrHigh: assert property (p_addrHigh)
      else $error("address high byte not captured");

   property p_addrExt;
      loadRise && action == `ACT_ADDR && sel == `SEL_EXT
         |=> st.address[`ADDR_EXT_RANGE] == $past(dataIn);
   endproperty
   a_addrExt: assert property (p_addrExt)
      else $error("extended address byte not captured");

   property p_dataHigh;
      loadRise && action == `ACT_DATA && byteSelect1
         |=> st.dataHi == $past(dataIn) && $stable(st.dataLo);
   endproperty
   a_dataHigh: assert property (p_dataHigh)
      else $error("data high byte not captured");

   property p_lockOnlyClears;
      !eraseStart |=> (st.lockBits & ~$past(st.lockBits)) == 8'h00;
   endproperty
   a_lockOnlyClears: assert property (p_lockOnlyClears)
      else $error("lock bit returned high without erase");

   property p_bootFrozen;
      lockModeThree && !eraseStart |=> $stable(st.lockBits[`BOOT_LOCK_RANGE]);
   endproperty
   a_bootFrozen: assert property (p_bootFrozen)
      else $error("boot lock bits changed in lock mode three");

   property p_nopClears;
      loadRise && action == `ACT_CMD && dataIn == `CMD_NOP
         |=> st.dataLo == `ERASED_BYTE && st.dataHi == `ERASED_BYTE;
   endproperty
   a_nopClears: assert property (p_nopClears)
      else $error("no-operation left write data");

   property p_busyIgnores;
      writeFall && !st.ready |=> $stable(st.fuseLow) && $stable(st.fuseHigh);
   endproperty
   a_busyIgnores: assert property (p_busyIgnores)
      else $error("write accepted while busy");

   property p_flashReadLow;
      st.command == `CMD_READ_FLASH && !byteSelect1
         |=> dataOut == $past(mem.flashWord[7:0]);
   endproperty
   a_flashReadLow: assert property (p_flashReadLow)
      else $error("flash low byte not presented");
endmodule

/* File: rtl/nvm_prog_map.svh */
// constants of the parallel programming port: codes, fields, timing
`ifndef NVM_PROG_MAP_SVH
`define NVM_PROG_MAP_SVH

`define CMD_CHIP_ERASE     8'h80
`define CMD_WRITE_FUSE     8'h40
`define CMD_WRITE_LOCK     8'h20
`define CMD_WRITE_FLASH    8'h10
`define CMD_WRITE_EEPROM   8'h11
`define CMD_READ_SIG       8'h08
`define CMD_READ_FUSE      8'h04
`define CMD_READ_FLASH     8'h02
`define CMD_READ_EEPROM    8'h03
`define CMD_NOP            8'h00

`define ACT_ADDR           2'h0
`define ACT_DATA           2'h1
`define ACT_CMD            2'h2
`define ACT_IDLE           2'h3

`define SEL_LOW            2'h0
`define SEL_HIGH           2'h1
`define SEL_EXT            2'h2
`define SEL_BOTH           2'h3

`define ADDR_LOW_RANGE     7:0
`define ADDR_HIGH_RANGE    15:8
`define ADDR_EXT_RANGE     23:16
`define LOCK_MODE_RANGE    1:0
`define BOOT_LOCK_RANGE    5:2
`define LOCK_MODE_THREE    2'h0

`define ERASED_BYTE        8'hFF
`define ERASED_WORD        16'hFFFF
`define SIG_LAST_ADDR      8'h02
`define CAL_ADDR           8'h00

`define CLK_PERIOD_NS      4.0
`define T_WLRH_MIN_MS      3.7
`define T_WLRH_CE_MIN_MS   7.5
`define NS_PER_MS          1.0E6

`endif

/* File: rtl/nvm_prog_pkg.sv */
// types shared by the programming port and its storage
package nvm_prog_pkg;
   typedef enum logic [3:0] {
      OP_IDLE   = 4'b0001,
      OP_FLASH  = 4'b0010,
      OP_EEPROM = 4'b0100,
      OP_ERASE  = 4'b1000
   } walk_op_type;
endpackage

/* File: rtl/nvm_array_if.sv */
// link between the port control and the nonvolatile storage
`timescale 1ns/10ps
interface nvm_array_if;
   logic [23:0] address;
   logic [7:0]  dataLo;
   logic [7:0]  dataHi;
   logic        flashLatch;
   logic        eepromLatch;
   logic        flashCommit;
   logic        eepromCommit;
   logic        eraseAll;
   logic [15:0] flashWord;
   logic [7:0]  eepromByte;

   modport ctrl (
      output address, dataLo, dataHi, flashLatch, eepromLatch,
             flashCommit, eepromCommit, eraseAll,
      input  flashWord, eepromByte
   );
   modport store (
      input  address, dataLo, dataHi, flashLatch, eepromLatch,
             flashCommit, eepromCommit, eraseAll,
      output flashWord, eepromByte
   );
endinterface

/* File: rtl/nvm_array.sv */
// flash and eeprom arrays with their page buffers
`timescale 1ns/10ps
`include "nvm_prog_map.svh"
module nvm_array
   import nvm_prog_pkg::*;
#(
   parameter int FLASH_AW   = 15,
   parameter int PAGE_BITS  = 7,
   parameter int EE_AW      = 11,
   parameter int EE_PG_BITS = 3
) (
   input  wire logic  clk_sys,
   input  wire logic  sys_rst,
   nvm_array_if.store mem
);
   localparam int FP_W = FLASH_AW - PAGE_BITS;
   localparam int EP_W = EE_AW - EE_PG_BITS;

   initial begin
      if (PAGE_BITS < 1 || EE_PG_BITS < 1 || EE_AW > FLASH_AW ||
          PAGE_BITS >= FLASH_AW || EE_PG_BITS >= EE_AW || FLASH_AW > 24)
         $error("nvm_array: unsupported geometry");
   end

   typedef struct packed {
      walk_op_type           op;
      logic [FLASH_AW-1:0]   walk;
      logic [FP_W-1:0]       flashPage;
      logic [EP_W-1:0]       eepromPage;
   } state_type;

   state_type st;
   state_type next_st;

   logic [15:0] flashMem [2**FLASH_AW];
   logic [15:0] flashBuf [2**PAGE_BITS];
   logic [7:0]  eeMem    [2**EE_AW];
   logic [7:0]  eeBuf    [2**EE_PG_BITS];

   logic [PAGE_BITS-1:0]  flashIdx;
   logic [EE_PG_BITS-1:0] eeIdx;

   // low address bits pick the word in the page, upper bits the page
   assign flashIdx = mem.address[PAGE_BITS-1:0];
   assign eeIdx    = mem.address[EE_PG_BITS-1:0];
   assign mem.flashWord  = flashMem[mem.address[FLASH_AW-1:0]];
   assign mem.eepromByte = eeMem[mem.address[EE_AW-1:0]];

   always_comb begin
      next_st = st;
      case (st.op)
         OP_IDLE: begin
            next_st.walk = '0;
            if (mem.eraseAll) begin
               next_st.op = OP_ERASE;
            end else if (mem.flashCommit) begin
               next_st.op = OP_FLASH;
               next_st.flashPage = mem.address[FLASH_AW-1:PAGE_BITS];
            end else if (mem.eepromCommit) begin
               next_st.op = OP_EEPROM;
               next_st.eepromPage = mem.address[EE_AW-1:EE_PG_BITS];
            end
         end
         OP_FLASH: begin
            next_st.walk = st.walk + 1'b1;
            if (st.walk[PAGE_BITS-1:0] == '1) next_st.op = OP_IDLE;
         end
         OP_EEPROM: begin
            next_st.walk = st.walk + 1'b1;
            if (st.walk[EE_PG_BITS-1:0] == '1) next_st.op = OP_IDLE;
         end
         OP_ERASE: begin
            next_st.walk = st.walk + 1'b1;
            if (st.walk == '1) next_st.op = OP_IDLE;
         end
         default: next_st.op = OP_IDLE;
      endcase
   end

   // buffers refill with erased data once copied, so a short page leaves
   // untouched words erased
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         st <= '{op: OP_IDLE, walk: '0, flashPage: '0, eepromPage: '0};
      end else begin
         st <= next_st;
      end
      if (st.op == OP_FLASH) begin
         flashMem[{st.flashPage, st.walk[PAGE_BITS-1:0]}] <=
            flashBuf[st.walk[PAGE_BITS-1:0]];
         flashBuf[st.walk[PAGE_BITS-1:0]] <= `ERASED_WORD;
      end
      if (st.op == OP_EEPROM) begin
         eeMem[{st.eepromPage, st.walk[EE_PG_BITS-1:0]}] <=
            eeBuf[st.walk[EE_PG_BITS-1:0]];
         eeBuf[st.walk[EE_PG_BITS-1:0]] <= `ERASED_BYTE;
      end
      if (st.op == OP_ERASE) begin
         flashMem[st.walk] <= `ERASED_WORD;
         eeMem[st.walk[EE_AW-1:0]] <= `ERASED_BYTE;
         flashBuf[st.walk[PAGE_BITS-1:0]] <= `ERASED_WORD;
         eeBuf[st.walk[EE_PG_BITS-1:0]] <= `ERASED_BYTE;
      end
      if (mem.flashLatch) begin
         flashBuf[flashIdx] <= {mem.dataHi, mem.dataLo};
      end
      if (mem.eepromLatch) begin
         eeBuf[eeIdx] <= mem.dataLo;
      end
   end
endmodule

/* File: tb/nvm_programmer.sv */
// model of the external parallel programmer driving the port pins
`timescale 1ns/10ps
module nvm_programmer (
   input  wire logic       clk_sys,
   input  wire logic       readyFlag,
   input  wire logic [7:0] dataBus,
   output logic            loadStrobe,
   output logic            loadActionSelectHi,
   output logic            loadActionSelectLo,
   output logic            byteSelect1,
   output logic            byteSelect2,
   output logic            wordLatchStrobe,
   output logic            programStartStrobeN,
   output logic            outputEnableN,
   output logic [7:0]      progData,
   output logic            progDrive
);
   initial begin
      loadStrobe = 1'b0;
      {loadActionSelectHi, loadActionSelectLo} = 2'h3;
      {byteSelect2, byteSelect1} = 2'h0;
      wordLatchStrobe = 1'b0;
      programStartStrobeN = 1'b1;
      outputEnableN = 1'b1;
      progData = 8'h00;
      progDrive = 1'b1;
   end

   // one strobe pulse, high one clock and low one clock
   task automatic load(input logic [1:0] act, input logic [1:0] sel,
                       input logic [7:0] d);
      @(negedge clk_sys);
      {loadActionSelectHi, loadActionSelectLo} = act;
      {byteSelect2, byteSelect1} = sel;
      progData = d;
      loadStrobe = 1'b1;
      @(negedge clk_sys);
      loadStrobe = 1'b0;
      @(negedge clk_sys);
   endtask

   task automatic latch(input logic bs1);
      @(negedge clk_sys);
      byteSelect1 = bs1;
      wordLatchStrobe = 1'b1;
      @(negedge clk_sys);
      wordLatchStrobe = 1'b0;
      @(negedge clk_sys);
   endtask

   // one write pulse, low for one clock; a busy device drops it
   task automatic pulseWrite(input logic [1:0] sel);
      @(negedge clk_sys);
      {byteSelect2, byteSelect1} = sel;
      programStartStrobeN = 1'b0;
      @(negedge clk_sys);
      programStartStrobeN = 1'b1;
   endtask

   // counts the clocks spent busy; bounded so a stuck flag cannot hang
   task automatic waitReady(output int n);
      n = 0;
      while (readyFlag !== 1'b1 && n < 5000) begin
         n++;
         @(negedge clk_sys);
      end
      {byteSelect2, byteSelect1} = 2'h0;
   endtask

   task automatic commit(input logic [1:0] sel, output int n);
      pulseWrite(sel);
      waitReady(n);
   endtask

   // bus released half a clock before the device drives, retaken after
   task automatic read(input logic [1:0] sel, output logic [7:0] v);
      @(negedge clk_sys);
      {byteSelect2, byteSelect1} = sel;
      progDrive = 1'b0;
      outputEnableN = 1'b0;
      @(negedge clk_sys);
      @(negedge clk_sys);
      v = dataBus;
      outputEnableN = 1'b1;
      @(negedge clk_sys);
      progDrive = 1'b1;
   endtask
endmodule

/* File: tb/parallel_nvm_programming_port_bench.sv */
// self-checking bench of the parallel programming port
`timescale 1ns/10ps
module parallel_nvm_programming_port_bench;
   localparam int         PROG_N  = 300;
   localparam int         ERASE_N = 600;
   localparam logic [7:0] SIG0    = 8'h5A; // arbitrary value
   localparam logic [7:0] SIG1    = 8'h3C; // arbitrary value
   localparam logic [7:0] SIG2    = 8'h01; // arbitrary value
   localparam logic [7:0] CAL     = 8'h80;
   logic       clk_sys = 1'b0;
   logic       sys_rst = 1'b1;
   logic       loadStrobe, actHi, actLo, bs1, bs2, latchS, wrN, oeN;
   logic [7:0] dataOut, progData, dataBus;
   logic [7:0] lastBus = 8'h00;
   logic       dataOe, readyFlag, progDrive;
   int         num_errors = 0;
   int         comparisons = 0;

   always #2 clk_sys = ~clk_sys;
   // a floating bus must not read as a lucky match
   assign dataBus = dataOe ? dataOut : progDrive ? progData : ~lastBus;
   always @(posedge clk_sys) lastBus <= dataBus;

   // eeprom kept no wider than flash so the erase walk covers it
   parallel_nvm_programming_port #(.FLASH_AW(9), .EE_AW(9),
      .PROG_CYCLES(PROG_N), .ERASE_CYCLES(ERASE_N), .SIGNATURE_0(SIG0),
      .SIGNATURE_1(SIG1), .SIGNATURE_2(SIG2), .CALIBRATION(CAL)) i_dut (
      .clk_sys(clk_sys), .sys_rst(sys_rst), .loadStrobe(loadStrobe),
      .loadActionSelectHi(actHi), .loadActionSelectLo(actLo),
      .byteSelect1(bs1), .byteSelect2(bs2), .wordLatchStrobe(latchS),
      .programStartStrobeN(wrN), .outputEnableN(oeN), .dataIn(dataBus),
      .dataOut(dataOut), .dataOe(dataOe), .readyFlag(readyFlag));

   nvm_programmer i_prog (
      .clk_sys(clk_sys), .readyFlag(readyFlag), .dataBus(dataBus),
      .loadStrobe(loadStrobe), .loadActionSelectHi(actHi),
      .loadActionSelectLo(actLo), .byteSelect1(bs1), .byteSelect2(bs2),
      .wordLatchStrobe(latchS), .programStartStrobeN(wrN),
      .outputEnableN(oeN), .progData(progData), .progDrive(progDrive));

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         num_errors++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic cmd(input logic [7:0] c);
      i_prog.load(2'h2, 2'h0, c);
   endtask
   task automatic adr(input logic [1:0] sel, input logic [7:0] d);
      i_prog.load(2'h0, sel, d);
   endtask
   task automatic dat(input logic [1:0] sel, input logic [7:0] d);
      i_prog.load(2'h1, sel, d);
   endtask
   task automatic wr(input logic [1:0] sel, input int expN);
      int n;
      i_prog.commit(sel, n);
      check(n, expN);
   endtask
   task automatic rd(input logic [1:0] sel, input logic [7:0] exp);
      logic [7:0] v;
      i_prog.read(sel, v);
      check(v, exp);
      check(dataOe, 1'b0);
   endtask

   task automatic close_out;
      $display("comparisons %0d, mismatches %0d", comparisons, num_errors);
      if (num_errors == 0 && comparisons > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   initial begin
      #(20000 * 4);
      num_errors++;
      close_out;
   end

   initial begin
      logic [7:0] sig [3];
      int         busyLeft;
      sig = '{SIG0, SIG1, SIG2};
      repeat (6) @(negedge clk_sys);
      sys_rst = 1'b0;
      check(readyFlag, 1'b1);
      check(dataOe, 1'b0);
      cmd(8'h80);
      wr(2'h0, ERASE_N);
      $display("reset and erase done");
      // page 1 of the flash: top bit of the low byte picks the page
      cmd(8'h10);
      adr(2'h2, 8'h00);
      adr(2'h1, 8'h00);
      for (int k = 8'h81; k <= 8'h82; k++) begin
         adr(2'h0, 8'(k));
         dat(2'h0, 8'(k));
         dat(2'h1, ~8'(k));
         i_prog.latch(1'b1);
      end
      wr(2'h0, PROG_N);
      cmd(8'h00);
      cmd(8'h02);
      adr(2'h2, 8'h00);
      adr(2'h1, 8'h00);
      adr(2'h0, 8'h81);
      rd(2'h0, 8'h81);
      rd(2'h1, 8'h7E);
      adr(2'h0, 8'h82);
      rd(2'h1, 8'h7D);
      adr(2'h0, 8'h01);
      rd(2'h0, 8'hFF);
      adr(2'h1, 8'h01);
      adr(2'h0, 8'h81);
      rd(2'h0, 8'hFF);
      $display("flash test done");
      cmd(8'h11);
      adr(2'h1, 8'h00);
      adr(2'h0, 8'h05);
      dat(2'h0, 8'h3C);
      i_prog.latch(1'b0);
      wr(2'h0, PROG_N);
      cmd(8'h03);
      rd(2'h0, 8'h3C);
      $display("eeprom test done");
      cmd(8'h40);
      dat(2'h0, 8'h12);
      wr(2'h0, PROG_N);
      // a second pulse while busy must leave the low fuses alone
      dat(2'h0, 8'h34);
      i_prog.pulseWrite(2'h1);
      dat(2'h0, 8'h00);
      i_prog.pulseWrite(2'h0);
      i_prog.waitReady(busyLeft);
      check(busyLeft, PROG_N - 5);
      dat(2'h0, 8'h56);
      wr(2'h2, PROG_N);
      cmd(8'h04);
      rd(2'h0, 8'h12);
      rd(2'h3, 8'h34);
      rd(2'h2, 8'h56);
      $display("fuse test done");
      // mode three first, then a write that would clear boot bits
      cmd(8'h20);
      dat(2'h0, 8'hF0);
      wr(2'h0, PROG_N);
      dat(2'h0, 8'hC3);
      wr(2'h0, PROG_N);
      dat(2'h0, 8'hFF);
      wr(2'h0, PROG_N);
      cmd(8'h04);
      rd(2'h1, 8'hF0);
      cmd(8'h80);
      wr(2'h0, ERASE_N);
      cmd(8'h04);
      rd(2'h1, 8'hFF);
      $display("lock test done");
      cmd(8'h08);
      for (int i = 0; i < 3; i++) begin
         adr(2'h0, 8'(i));
         rd(2'h0, sig[i]);
      end
      adr(2'h0, 8'h00);
      rd(2'h1, CAL);
      i_prog.load(2'h3, 2'h0, 8'h02);
      rd(2'h0, SIG0);
      $display("signature test done");
      close_out;
   end
endmodule
